// ---- logic/amss_sequencer.sv ----
// Purpose: read/write cycle sequencer for asynchronous external memory
// Assumes: all phase counts in enabled periods of CLK_SYS_I (cycles with CLK_EN_I high)
// Notes:   read data passes a two-stage synchroniser before capture,
//          so it must be stable from two cycles before the capture cycle
`timescale 1ns/10ps

module amss_sequencer
  import amss_pkg::*;
(
  input  wire logic                   CLK_SYS_I,
  input  wire logic                   RESET_I,
  input  wire logic                   CLK_EN_I,
  input  wire logic                   REQ_VALID_I,
  input  wire logic                   REQ_WRITE_I,
  input  wire logic [CS_SEL_W-1:0]    REQ_CS_SEL_I,
  input  wire logic [WORD_ADDR_W-1:0] REQ_WORD_ADDR_I,
  input  wire logic [BYTE_ADDR_W-1:0] REQ_BYTE_ADDR_I,
  input  wire logic [DATA_W-1:0]      REQ_WDATA_I,
  output logic                        REQ_READY_O,
  output logic [DATA_W-1:0]           RDATA_O,
  output logic                        RDATA_VALID_O,
  output logic                        DONE_O,
  input  wire logic [SETUP_W-1:0]     READ_SETUP_CYCLES_I,
  input  wire logic [STROBE_W-1:0]    READ_STROBE_CYCLES_I,
  input  wire logic [HOLD_W-1:0]      READ_HOLD_CYCLES_I,
  input  wire logic [SETUP_W-1:0]     WRITE_SETUP_CYCLES_I,
  input  wire logic [STROBE_W-1:0]    WRITE_STROBE_CYCLES_I,
  input  wire logic [HOLD_W-1:0]      WRITE_HOLD_CYCLES_I,
  input  wire logic [TURN_W-1:0]      TURNAROUND_CYCLES_I,
  input  wire logic                   STROBE_SELECT_I,
  output logic [CS_COUNT-1:0]         MEM_CHIP_SELECT_N_O,
  output logic                        MEM_OUTPUT_ENABLE_N_O,
  output logic                        MEM_WRITE_ENABLE_N_O,
  output logic [WORD_ADDR_W-1:0]      MEM_WORD_ADDRESS_O,
  output logic [BYTE_ADDR_W-1:0]      MEM_BYTE_ADDRESS_O,
  input  wire logic [DATA_W-1:0]      MEM_DATA_BUS_I,
  output logic [DATA_W-1:0]           MEM_DATA_BUS_O,
  output logic                        MEM_DATA_BUS_OE_N_O
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_TURN
  } amss_state_t;

  amss_state_t            state_reg;
  amss_state_t            state_next;

  logic                   accept;
  logic                   en;
  logic                   phase_last;
  logic                   phase_last_next;
  logic                   phase_load;
  logic [PHASE_CNT_W-1:0] phase_val;

  // per-access settings, frozen at acceptance
  logic                   write_reg;
  logic                   ss_reg;
  logic [CS_SEL_W-1:0]    sel_reg;
  logic [SETUP_W-1:0]     setup_reg;
  logic [STROBE_W-1:0]    strobe_reg;
  logic [HOLD_W-1:0]      hold_reg;
  logic [TURN_W-1:0]      turn_reg;
  logic                   write_next;
  logic                   ss_next;
  logic [CS_SEL_W-1:0]    sel_next;
  logic [SETUP_W-1:0]     req_setup;
  logic [STROBE_W-1:0]    req_strobe;
  logic [HOLD_W-1:0]      req_hold;

  logic                   in_access_next;
  logic                   strobe_next;
  logic                   cs_active_next;
  logic [CS_COUNT-1:0]    cs_n_next;
  logic                   ready_next;
  logic                   capture_now;
  logic                   done_now;

  logic [CS_COUNT-1:0]    cs_n_reg;
  logic                   oe_n_reg;
  logic                   we_n_reg;
  logic [WORD_ADDR_W-1:0] word_addr_reg;
  logic [BYTE_ADDR_W-1:0] byte_addr_reg;
  logic [DATA_W-1:0]      wdata_reg;
  logic                   data_oe_n_reg;
  logic                   ready_reg;
  logic [DATA_W-1:0]      rdata_reg;
  logic                   rdata_valid_reg;
  logic                   done_reg;
  logic [DATA_W-1:0]      din_meta_reg;
  logic [DATA_W-1:0]      din_sync_reg;

  assign en     = CLK_EN_I;
  assign accept = REQ_VALID_I && ready_reg;

  // next state, moves only on enabled cycles
  always_comb begin
    state_next = state_reg;
    if (en) begin
      unique case (state_reg)
        ST_IDLE:   if (accept) state_next = ST_SETUP;
        ST_SETUP:  if (phase_last) state_next = ST_STROBE;
        ST_STROBE: if (phase_last) state_next = ST_HOLD;
        ST_HOLD:   if (phase_last) state_next = ST_TURN;
        ST_TURN: begin
          if (phase_last) begin
            state_next = accept ? ST_SETUP : ST_IDLE;
          end
        end
      endcase
    end
  end

  assign req_setup  = REQ_WRITE_I ? WRITE_SETUP_CYCLES_I : READ_SETUP_CYCLES_I;
  assign req_strobe = REQ_WRITE_I ? WRITE_STROBE_CYCLES_I : READ_STROBE_CYCLES_I;
  assign req_hold   = REQ_WRITE_I ? WRITE_HOLD_CYCLES_I : READ_HOLD_CYCLES_I;

  // each phase loads its field value N on entry and ends after N+1 cycles
  assign phase_load = (state_next != state_reg);
  assign phase_val  = (state_next == ST_SETUP)  ? PHASE_CNT_W'(req_setup) :
                      (state_next == ST_STROBE) ? PHASE_CNT_W'(strobe_reg) :
                      (state_next == ST_HOLD)   ? PHASE_CNT_W'(hold_reg) :
                      (state_next == ST_TURN)   ? PHASE_CNT_W'(turn_reg) :
                                                  PHASE_CNT_RST;

  amss_phase_counter u_phase (
    .clk_i       (CLK_SYS_I),
    .reset_i     (RESET_I),
    .en_i        (en),
    .load_i      (phase_load),
    .load_val_i  (phase_val),
    .last_o      (phase_last),
    .last_next_o (phase_last_next)
  );

  assign write_next = accept ? REQ_WRITE_I : write_reg;
  assign ss_next    = accept ? STROBE_SELECT_I : ss_reg;
  assign sel_next   = accept ? REQ_CS_SEL_I : sel_reg;

  // pin values for the coming cycle, registered so pins come from flops
  assign in_access_next = (state_next == ST_SETUP) || (state_next == ST_STROBE) ||
                          (state_next == ST_HOLD);
  assign strobe_next    = (state_next == ST_STROBE);
  // strobe select lets chip select follow the strobe itself
  assign cs_active_next = ss_next ? strobe_next : in_access_next;
  assign cs_n_next      = cs_active_next ? ~(CS_ONE_HOT << sel_next) : CS_IDLE_N;
  assign ready_next     = (state_next == ST_IDLE) ||
                          ((state_next == ST_TURN) && phase_last_next);
  assign capture_now    = en && (state_reg == ST_STROBE) && phase_last && !write_reg;
  assign done_now       = en && (state_reg == ST_TURN) && phase_last;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b0;
    end else if (en) begin
      state_reg <= state_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      write_reg  <= 1'b0;
      ss_reg     <= 1'b0;
      sel_reg    <= '0;
      setup_reg  <= '0;
      strobe_reg <= '0;
      hold_reg   <= '0;
      turn_reg   <= '0;
    end else if (en && accept) begin
      write_reg  <= REQ_WRITE_I;
      ss_reg     <= STROBE_SELECT_I;
      sel_reg    <= REQ_CS_SEL_I;
      setup_reg  <= req_setup;
      strobe_reg <= req_strobe;
      hold_reg   <= req_hold;
      turn_reg   <= TURNAROUND_CYCLES_I;
    end
  end

  // memory pins; address and write data held from setup through turnaround
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      cs_n_reg      <= CS_IDLE_N;
      oe_n_reg      <= 1'b1;
      we_n_reg      <= 1'b1;
      data_oe_n_reg <= 1'b1;
    end else if (en) begin
      cs_n_reg      <= cs_n_next;
      oe_n_reg      <= !(strobe_next && !write_next);
      we_n_reg      <= !(strobe_next && write_next);
      data_oe_n_reg <= !(in_access_next && write_next);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      word_addr_reg <= WORD_ADDR_RST;
      byte_addr_reg <= BYTE_ADDR_RST;
      wdata_reg     <= DATA_RST;
    end else if (en && accept) begin
      word_addr_reg <= REQ_WORD_ADDR_I;
      byte_addr_reg <= REQ_BYTE_ADDR_I;
      wdata_reg     <= REQ_WDATA_I;
    end
  end

  // read data synchroniser and capture
  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      din_meta_reg    <= DATA_RST;
      din_sync_reg    <= DATA_RST;
      rdata_reg       <= DATA_RST;
      rdata_valid_reg <= 1'b0;
      done_reg        <= 1'b0;
    end else if (en) begin
      din_meta_reg    <= MEM_DATA_BUS_I;
      din_sync_reg    <= din_meta_reg;
      rdata_valid_reg <= capture_now;
      done_reg        <= done_now;
      if (capture_now) begin
        rdata_reg <= din_sync_reg;
      end
    end
  end

  assign REQ_READY_O           = ready_reg;
  assign RDATA_O               = rdata_reg;
  assign RDATA_VALID_O         = rdata_valid_reg;
  assign DONE_O                = done_reg;
  assign MEM_CHIP_SELECT_N_O   = cs_n_reg;
  assign MEM_OUTPUT_ENABLE_N_O = oe_n_reg;
  assign MEM_WRITE_ENABLE_N_O  = we_n_reg;
  assign MEM_WORD_ADDRESS_O    = word_addr_reg;
  assign MEM_BYTE_ADDRESS_O    = byte_addr_reg;
  assign MEM_DATA_BUS_O        = wdata_reg;
  assign MEM_DATA_BUS_OE_N_O   = data_oe_n_reg;

  // checking helpers: cycles spent in the current phase and in the access
  logic [PHASE_CNT_W-1:0] phase_run_reg;
  logic [ACC_CNT_W-1:0]   acc_run_reg;
  logic                   phase_end;
  logic [ACC_CNT_W-1:0]   acc_expect;

  assign phase_end  = en && (state_reg != ST_IDLE) && (state_next != state_reg);
  assign acc_expect = ACC_CNT_W'(setup_reg) + ACC_CNT_W'(strobe_reg) +
                      ACC_CNT_W'(hold_reg) + ACC_CNT_W'(turn_reg) + ACCESS_EXTRA;

  always_ff @(posedge CLK_SYS_I) begin
    if (RESET_I) begin
      phase_run_reg <= PHASE_CNT_RST;
      acc_run_reg   <= '0;
    end else if (en) begin
      phase_run_reg <= (state_next != state_reg) ? PHASE_CNT_RST
                                                  : phase_run_reg + 6'h01;
      if (state_next == ST_SETUP && state_reg != ST_SETUP) begin
        acc_run_reg <= 8'h01;
      end else if (state_reg != ST_IDLE) begin
        acc_run_reg <= acc_run_reg + 8'h01;
      end
    end
  end

  AST_TURN_LEN: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (phase_end && state_reg == ST_TURN) |->
      (phase_run_reg == PHASE_CNT_W'(turn_reg)) && (cs_n_reg == CS_IDLE_N))
    else $error("turnaround length or chip select wrong");

  AST_RD_CYCLE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (done_now && !write_reg) |-> (acc_run_reg == acc_expect))
    else $error("read cycle length wrong");

  AST_WR_CYCLE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (done_now && write_reg) |-> (acc_run_reg == acc_expect))
    else $error("write cycle length wrong");

  AST_SETUP_LEN: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (phase_end && state_reg == ST_SETUP) |->
      (phase_run_reg == PHASE_CNT_W'(setup_reg)) && oe_n_reg && we_n_reg &&
      (ss_reg || cs_n_reg != CS_IDLE_N) ##1 (!oe_n_reg || !we_n_reg))
    else $error("setup phase length or pins wrong");

  AST_SS_CS: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (ss_reg && state_reg != ST_IDLE) |->
      ((cs_n_reg != CS_IDLE_N) == (!oe_n_reg || !we_n_reg)))
    else $error("strobe select chip select not following strobe");

  AST_SS_RELEASE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (en && ss_reg && !oe_n_reg && state_next == ST_HOLD) |=>
      (oe_n_reg && cs_n_reg == CS_IDLE_N))
    else $error("strobe select chip select not released with strobe");

  AST_ADDR_STABLE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_reg == ST_SETUP || state_reg == ST_STROBE || state_reg == ST_HOLD) &&
      (state_next != ST_SETUP) |=>
      $stable(word_addr_reg) && $stable(byte_addr_reg) && $stable(wdata_reg))
    else $error("address or write data changed inside access");

  AST_HOLD_LEN: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (phase_end && state_reg == ST_HOLD) |->
      (phase_run_reg == PHASE_CNT_W'(hold_reg)) && oe_n_reg && we_n_reg &&
      (ss_reg || cs_n_reg != CS_IDLE_N) ##1 (cs_n_reg == CS_IDLE_N))
    else $error("hold phase length or chip select wrong");

  AST_OE_WIDTH: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (phase_end && state_reg == ST_STROBE && !write_reg) |->
      (phase_run_reg == PHASE_CNT_W'(strobe_reg)) && !oe_n_reg && we_n_reg)
    else $error("output enable low width wrong");

  AST_BYTE_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (en && state_reg == ST_STROBE && state_next == ST_HOLD) |=>
      (byte_addr_reg == $past(byte_addr_reg)) && (state_reg == ST_HOLD))
    else $error("byte address not held after strobe");

  AST_WE_WIDTH: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (phase_end && state_reg == ST_STROBE && write_reg) |->
      (phase_run_reg == PHASE_CNT_W'(strobe_reg)) && !we_n_reg && oe_n_reg)
    else $error("write enable low width wrong");

  AST_WDATA_DRIVE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (state_reg == ST_SETUP || state_reg == ST_STROBE || state_reg == ST_HOLD) |->
      (data_oe_n_reg == !write_reg))
    else $error("write data drive window wrong");

  AST_WORD_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (en && write_reg && !we_n_reg && state_next == ST_HOLD) |=>
      $stable(word_addr_reg) && we_n_reg)
    else $error("write word address not held");

  AST_RD_CAPTURE: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    capture_now |-> !oe_n_reg ##1 (rdata_valid_reg && rdata_reg == $past(din_sync_reg)))
    else $error("read data not captured at strobe end");

  AST_NO_DRIVE_RD: assert property (@(posedge CLK_SYS_I) disable iff (RESET_I)
    (!oe_n_reg || state_reg == ST_TURN || state_reg == ST_IDLE) |-> data_oe_n_reg)
    else $error("data bus driven during read or turnaround");

endmodule // amss_sequencer

// ---- logic/amss_pkg.sv ----
// Purpose: shared constants of the asynchronous memory strobe sequencer
// Assumes: one external memory port, active-low chip selects
// Notes:   field widths are fixed; counts are in interface clock periods
package amss_pkg;

  localparam int unsigned CS_COUNT      = 4;
  localparam int unsigned CS_SEL_W      = 2;
  localparam int unsigned WORD_ADDR_W   = 22;
  localparam int unsigned BYTE_ADDR_W   = 2;
  localparam int unsigned DATA_W        = 16;

  // programmable phase fields, each value N lasts N+1 periods
  localparam int unsigned SETUP_W       = 4;
  localparam int unsigned STROBE_W      = 6;
  localparam int unsigned HOLD_W        = 3;
  localparam int unsigned TURN_W        = 2;
  localparam int unsigned PHASE_CNT_W   = 6;
  localparam int unsigned ACC_CNT_W     = 8;

  // number of extra periods of a full access beyond the field sum
  localparam logic [ACC_CNT_W-1:0]   ACCESS_EXTRA   = 8'h04;

  // reset and idle values of the memory pins and phase counter, and the one-hot chip select base
  localparam logic [CS_COUNT-1:0]    CS_IDLE_N      = 4'hF;
  localparam logic [CS_COUNT-1:0]    CS_ONE_HOT     = 4'h1;
  localparam logic [WORD_ADDR_W-1:0] WORD_ADDR_RST  = 22'h000000;
  localparam logic [BYTE_ADDR_W-1:0] BYTE_ADDR_RST  = 2'h0;
  localparam logic [DATA_W-1:0]      DATA_RST       = 16'h0000;
  localparam logic [PHASE_CNT_W-1:0] PHASE_CNT_RST  = 6'h00;

endpackage

// ---- logic/amss_phase_counter.sv ----
// Purpose: down counter that times one sequencer phase
// Assumes: load value N gives a phase of N+1 enabled cycles
// Notes:   last_next_o lets the caller register outputs ahead of time
`timescale 1ns/10ps
module amss_phase_counter
  import amss_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   en_i,
  input  wire logic                   load_i,
  input  wire logic [PHASE_CNT_W-1:0] load_val_i,
  output logic                        last_o,
  output logic                        last_next_o
);

  logic [PHASE_CNT_W-1:0] cnt_reg;
  logic [PHASE_CNT_W-1:0] cnt_next;
  logic [PHASE_CNT_W-1:0] cnt_dec;

  assign cnt_dec     = (cnt_reg == PHASE_CNT_RST) ? PHASE_CNT_RST
                                                   : cnt_reg - 6'h01;
  assign cnt_next    = !en_i ? cnt_reg : (load_i ? load_val_i : cnt_dec);
  assign last_o      = (cnt_reg == PHASE_CNT_RST);
  assign last_next_o = (cnt_next == PHASE_CNT_RST);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_reg <= PHASE_CNT_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule // amss_phase_counter

// ---- bench/amss_mem_model.sv ----
// Purpose: behavioural asynchronous memory beside the strobe sequencer
// Assumes: sixteen words, picked by the low word address bits
// Notes:   a released bus shows the inverse of the last word driven
`timescale 1ns/10ps
module amss_mem_model
  import amss_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic [CS_COUNT-1:0]    cs_n_i,
  input  wire logic                   oe_n_i,
  input  wire logic                   we_n_i,
  input  wire logic [WORD_ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0]      wdata_i,
  output logic      [DATA_W-1:0]      rdata_o
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last_q;
  logic              sel_w;
  assign sel_w = (cs_n_i != CS_IDLE_N);
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 16'hA5C0 | 16'(i);
    last_q = 16'h0000;
  end
  always @(posedge clk_i) begin
    if (sel_w && !we_n_i) mem[addr_i[3:0]] <= wdata_i;
    if (sel_w && !oe_n_i) last_q <= mem[addr_i[3:0]];
  end
  // drives only while selected and output enable low
  assign rdata_o = (sel_w && !oe_n_i) ? mem[addr_i[3:0]] : ~last_q;
endmodule // amss_mem_model

// ---- bench/testbench.sv ----
// Purpose: self-checking bench of the memory strobe sequencer
// Assumes: request and config driven at the falling edge
// Notes:   pins are judged each cycle against a map counted from accept
`timescale 1ns/10ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, (e), (g)); end end
module testbench;
  import amss_pkg::*;
  typedef struct packed {
    logic wr; logic ss; logic [CS_SEL_W-1:0] sel;
    logic [SETUP_W-1:0] su; logic [STROBE_W-1:0] sb;
    logic [HOLD_W-1:0] hd; logic [TURN_W-1:0] tn;
    logic [WORD_ADDR_W-1:0] wa; logic [BYTE_ADDR_W-1:0] ba;
    logic [DATA_W-1:0] wd; logic [DATA_W-1:0] rd;
  } amss_exp_t;
  logic                   clk_sys, reset, req_valid, req_write, strobe_sel, ready;
  logic                   rvalid, done, oe_n, we_n, doe_n;
  logic [CS_SEL_W-1:0]    req_sel;
  logic [WORD_ADDR_W-1:0] req_wa, waddr;
  logic [BYTE_ADDR_W-1:0] req_ba, baddr;
  logic [DATA_W-1:0]      req_wd, rdata, dout, mem_q;
  logic [SETUP_W-1:0]     rd_setup, wr_setup;
  logic [STROBE_W-1:0]    rd_strobe, wr_strobe;
  logic [HOLD_W-1:0]      rd_hold, wr_hold;
  logic [TURN_W-1:0]      turn;
  logic [CS_COUNT-1:0]    csn, cs_exp;
  logic                   clk_en = 1'b1;
  logic [DATA_W-1:0]      shadow [16];
  wire logic [DATA_W-1:0] din;
  amss_exp_t              eq[$];
  amss_exp_t              x;
  int                     sq[$];
  int                     cyc, ecyc, idx, hold_end, num_errors, comparisons;
  bit                     seen_rv, strobe_on, cs_on, en_q, rst_q;

  assign din = doe_n ? mem_q : dout;

  amss_sequencer DUT (
    .CLK_SYS_I(clk_sys), .RESET_I(reset), .CLK_EN_I(clk_en),
    .REQ_VALID_I(req_valid), .REQ_WRITE_I(req_write), .REQ_CS_SEL_I(req_sel),
    .REQ_WORD_ADDR_I(req_wa), .REQ_BYTE_ADDR_I(req_ba), .REQ_WDATA_I(req_wd),
    .REQ_READY_O(ready), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .DONE_O(done),
    .READ_SETUP_CYCLES_I(rd_setup), .READ_STROBE_CYCLES_I(rd_strobe),
    .READ_HOLD_CYCLES_I(rd_hold), .WRITE_SETUP_CYCLES_I(wr_setup),
    .WRITE_STROBE_CYCLES_I(wr_strobe), .WRITE_HOLD_CYCLES_I(wr_hold),
    .TURNAROUND_CYCLES_I(turn), .STROBE_SELECT_I(strobe_sel),
    .MEM_CHIP_SELECT_N_O(csn), .MEM_OUTPUT_ENABLE_N_O(oe_n),
    .MEM_WRITE_ENABLE_N_O(we_n), .MEM_WORD_ADDRESS_O(waddr),
    .MEM_BYTE_ADDRESS_O(baddr), .MEM_DATA_BUS_I(din), .MEM_DATA_BUS_O(dout),
    .MEM_DATA_BUS_OE_N_O(doe_n)
  );

  amss_mem_model mem_far (
    .clk_i(clk_sys), .cs_n_i(csn), .oe_n_i(oe_n), .we_n_i(we_n),
    .addr_i(waddr), .wdata_i(dout), .rdata_o(mem_q)
  );

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // enable drops now and then so every phase must stretch, not shorten
  always @(negedge clk_sys) clk_en <= reset || ($urandom_range(0, 7) != 0);

  task automatic complete_run;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // unused direction gets inverted fields so a wrong pick shows up
  task automatic issue(input logic w, input int k);
    amss_exp_t e;
    int        n;
    @(negedge clk_sys);
    e.su = k == 0 ? 4'hF : k == 1 ? 4'h0 : SETUP_W'($urandom_range(0, 5));
    e.sb = k == 0 ? 6'h3F : k == 1 ? 6'h02 : STROBE_W'($urandom_range(2, 9));
    e.hd = k == 0 ? 3'h7 : k == 1 ? 3'h0 : HOLD_W'($urandom_range(0, 7));
    e.tn = k == 0 ? 2'h3 : k == 1 ? 2'h0 : TURN_W'($urandom_range(0, 3));
    e.wr = w;
    e.ss = 1'($urandom);
    e.sel = CS_SEL_W'($urandom);
    e.wa = WORD_ADDR_W'($urandom);
    e.ba = BYTE_ADDR_W'($urandom);
    e.wd = DATA_W'($urandom);
    e.rd = shadow[e.wa[3:0]];
    if (w) shadow[e.wa[3:0]] = e.wd;
    req_valid = 1'b1;
    req_write = w;
    strobe_sel = e.ss;
    req_sel = e.sel;
    req_wa = e.wa;
    req_ba = e.ba;
    req_wd = e.wd;
    rd_setup = w ? ~e.su : e.su;
    wr_setup = w ? e.su : ~e.su;
    rd_strobe = w ? ~e.sb : e.sb;
    wr_strobe = w ? e.sb : ~e.sb;
    rd_hold = w ? ~e.hd : e.hd;
    wr_hold = w ? e.hd : ~e.hd;
    turn = e.tn;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(ready && clk_en) && n < 300);
    eq.push_back(e);
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (clk_en) ecyc++;
    en_q = clk_en;
    rst_q = reset;
    if (!reset && clk_en && req_valid && ready) sq.push_back(ecyc);
    if (cyc > 20000) begin
      num_errors++;
      complete_run();
    end
  end

  always @(negedge clk_sys) begin
    if (en_q && done && eq.size() > 0 && sq.size() > 0) begin
      x = eq[0];
      `CHK("access length", x.su + x.sb + x.hd + x.tn + 4, ecyc - sq[0])
      `CHK("read pulse seen", !x.wr, seen_rv)
      void'(eq.pop_front());
      void'(sq.pop_front());
      seen_rv = 1'b0;
    end else if (en_q && done) `CHK("stray done", 1'b0, done)
    if (!rst_q && eq.size() > 0 && sq.size() > 0) begin
      x = eq[0];
      idx = ecyc - sq[0];
      hold_end = x.su + x.sb + x.hd + 3;
      strobe_on = idx > x.su && idx <= x.su + x.sb + 1;
      cs_on = x.ss ? strobe_on : idx < hold_end;
      `CHK("strobe", !strobe_on, x.wr ? we_n : oe_n)
      `CHK("idle strobe", 1'b1, x.wr ? oe_n : we_n)
      cs_exp = cs_on ? ~(CS_ONE_HOT << x.sel) : CS_IDLE_N;
      if (idx >= hold_end) `CHK("turn chip select", CS_IDLE_N, csn)
      else if (x.ss) `CHK("chip select", cs_exp, csn)
      else `CHK("chip select", cs_exp, csn)
      `CHK("ready", idx == hold_end + x.tn, ready)
      if (idx < hold_end) begin
        `CHK("word address", x.wa, waddr)
        `CHK("byte address", x.ba, baddr)
        `CHK("bus drive", !x.wr, doe_n)
        if (x.wr) `CHK("write data", x.wd, dout)
      end else `CHK("bus drive", 1'b1, doe_n)
      if (en_q && rvalid) begin
        `CHK("read pulse time", x.su + x.sb + 2, idx)
        `CHK("read data", x.rd, rdata)
        seen_rv = 1'b1;
      end
    end else if (!rst_q && en_q) `CHK("idle ready", 1'b1, ready)
  end

  initial begin
    int n;
    reset = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    strobe_sel = 1'b0;
    req_sel = '0;
    req_wa = '0;
    req_ba = '0;
    req_wd = '0;
    {rd_setup, wr_setup, rd_strobe, wr_strobe, rd_hold, wr_hold, turn} = '0;
    cyc = 0;
    num_errors = 0;
    comparisons = 0;
    seen_rv = 1'b0;
    for (int i = 0; i < 16; i++) shadow[i] = 16'hA5C0 | 16'(i);
    void'($urandom(53));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    reset = 1'b0;
    for (int k = 0; k < 40; k++) begin
      issue(1'($urandom), k);
      if ($urandom_range(0, 1)) begin
        @(negedge clk_sys);
        req_valid = 1'b0;
        repeat ($urandom_range(0, 3)) @(negedge clk_sys);
      end
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    n = 0;
    while (eq.size() > 0 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("pending accesses", 0, eq.size())
    complete_run();
  end
endmodule // testbench
